// file: rtl/mtsf_pkg.sv
// mtsf_pkg: shared constants and types for the server frame engine
package mtsf_pkg;
  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int          HDR_BYTES    = 7;
  localparam int          RELAY_COUNT  = 8;
  localparam int          DIN_COUNT    = 38;
  localparam int          REG_DEPTH    = 256;
  localparam int          REG_AW       = 8;
  localparam logic [7:0]  FC_RD_RELAY  = 8'h01;
  localparam logic [7:0]  FC_RD_DIN    = 8'h02;
  localparam logic [7:0]  FC_RD_REGS   = 8'h03;
  localparam logic [7:0]  FC_WR_RELAY  = 8'h05;
  localparam logic [7:0]  FC_WR_REGS   = 8'h10;
  localparam logic [15:0] RELAY_ON_VAL = 16'hFF00;
  localparam logic [15:0] RELAY_OFF_VAL = 16'h0000;
  localparam logic [7:0]  UNIT_MAX     = 8'hF7;
  localparam logic [7:0]  UNIT_RESET   = 8'h01;
  localparam logic [7:0]  RELAY_RESET  = 8'h00;
  localparam int          MAX_FRAME    = 260;

  typedef enum logic [2:0] {
    MTSF_IDLE,
    MTSF_RX,
    MTSF_EXEC,
    MTSF_TX,
    MTSF_WRITE
  } mtsf_state_t;
endpackage : mtsf_pkg

// file: rtl/mtsf_mem_if.sv
// mtsf_mem_if: port bundle between the frame engine and its register memory
`timescale 1ns/10ps
interface mtsf_mem_if;
  logic                     we;
  logic [mtsf_pkg::REG_AW-1:0] waddr;
  logic [15:0]              wdata;
  logic [mtsf_pkg::REG_AW-1:0] raddr;
  logic [15:0]              rdata;
  modport master (output we, output waddr, output wdata, output raddr, input rdata);
  modport slave  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : mtsf_mem_if

// file: rtl/mtsf_regmem.sv
// mtsf_regmem: 16-bit register store with registered read data
`timescale 1ns/10ps
module mtsf_regmem (
  input  wire logic  clock_i,
  mtsf_mem_if.slave  mem
);
  logic [15:0] store [mtsf_pkg::REG_DEPTH];
  logic [15:0] rdata_reg;

  // write port and one-cycle registered read
  always_ff @(posedge clock_i) begin
    if (mem.we) begin
      store[mem.waddr] <= mem.wdata;
    end
    rdata_reg <= store[mem.raddr];
  end
  assign mem.rdata = rdata_reg;
endmodule : mtsf_regmem

// file: rtl/mtsf_server.sv
// mtsf_server: request frame parser and response builder for the TCP server
// ------------------------------------------------------------
// Notes on behaviour
// - frame is seven-byte header, function code, then N data bytes
// - response echoes the transaction identifier of its request
// - length field counts unit id, function code and data bytes
// - unit id is station address, valid 0 to 247
// - function code is eight bits, range 1 to 255
// - code 01 returns relay on/off states
// - code 02 returns digital input states
// - code 03 returns contents of consecutive registers
// - code 05 forces one relay on or off
// - code 16 writes values into consecutive registers
// - sixteen-bit fields travel high byte first
// - eight relays addressed from zero
// - relay response is header, code, byte count, status bytes
// - first requested relay in bit0, one means on, unused bits zero
// - 38 digital inputs addressed from zero
// - input response is header, code, byte count, packed bytes
// - first requested input in bit0, ascending, one means on
// - every accepted request gets exactly one response frame
// - FF00 sets relay on, 0000 off, anything else no change
// ------------------------------------------------------------
`timescale 1ns/10ps
module mtsf_server #(
  parameter int REG_DEPTH = mtsf_pkg::REG_DEPTH
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_last_i,
  input  wire logic [7:0]  unit_addr_i,
  input  wire logic [37:0] din_i,
  input  wire logic        tx_ready_i,
  output logic [7:0]       tx_data_o,
  output logic             tx_valid_o,
  output logic             tx_last_o,
  output logic [7:0]       relay_o,
  output logic             busy_o
);
  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (REG_DEPTH != mtsf_pkg::REG_DEPTH) begin : g_chk
    $error("REG_DEPTH must match the register memory depth");
  end

  mtsf_mem_if mem ();
  mtsf_regmem mtsf_regmem_i (.clock_i(clock_i), .mem(mem));

  // three-stage sync for the digital input pins; change counts when 2 and 3 agree
  logic [37:0] din_s1_reg, din_s2_reg, din_s3_reg, din_val_reg, din_val_next;
  always_comb begin
    din_val_next = din_val_reg;
    for (int i = 0; i < 38; i++) begin
      if (din_s2_reg[i] == din_s3_reg[i]) din_val_next[i] = din_s3_reg[i];
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      din_s1_reg  <= '0;
      din_s2_reg  <= '0;
      din_s3_reg  <= '0;
      din_val_reg <= '0;
    end else begin
      din_s1_reg  <= din_i;
      din_s2_reg  <= din_s1_reg;
      din_s3_reg  <= din_s2_reg;
      din_val_reg <= din_val_next;
    end
  end

  // ------------------------------------------------------------
  // frame engine state
  // ------------------------------------------------------------
  mtsf_pkg::mtsf_state_t state_reg, state_next;
  logic [8:0]  rx_cnt_reg, rx_cnt_next;
  logic [15:0] tid_reg, tid_next;
  logic [15:0] pid_reg, pid_next;
  logic [7:0]  uid_reg, uid_next;
  logic [7:0]  fc_reg, fc_next;
  logic [15:0] start_reg, start_next;
  logic [15:0] qty_reg, qty_next;
  logic [7:0]  hi_reg, hi_next;
  logic [7:0]  relay_reg, relay_next;
  logic [8:0]  tx_cnt_reg, tx_cnt_next;
  logic [8:0]  tx_len_reg, tx_len_next;
  logic [7:0]  tx_data_reg, tx_data_next;
  logic        tx_valid_reg, tx_valid_next;
  logic        tx_last_reg, tx_last_next;
  logic        we_reg, we_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [7:0]  raddr_reg, raddr_next;
  logic        err_reg, err_next;
  logic        busy_reg, busy_next;

  // pack status bits starting at the requested index; upper bits read zero
  function automatic logic [7:0] pack_bits(input logic [63:0] src, input logic [15:0] first,
                                           input logic [15:0] qty, input logic [15:0] idx,
                                           input logic [15:0] limit);
    logic [7:0]  b;
    logic [15:0] n;
    b = 8'h00;
    for (int k = 0; k < 8; k++) begin
      n = 16'((idx << 3) + 16'(k));
      if (n < qty && (first + n) < limit) b[k] = src[6'(first + n)];
    end
    return b;
  endfunction : pack_bits

  // response byte count for bit reads and register reads
  logic [15:0] bit_bytes, reg_bytes, data_bytes;
  always_comb begin
    bit_bytes = 16'((qty_reg + 16'd7) >> 3);
    reg_bytes = 16'(qty_reg << 1);
    case (fc_reg)
      mtsf_pkg::FC_RD_RELAY, mtsf_pkg::FC_RD_DIN: data_bytes = bit_bytes;
      mtsf_pkg::FC_RD_REGS:                       data_bytes = reg_bytes;
      default:                                    data_bytes = 16'd4;
    endcase
  end

  // outgoing byte chooser by position in the response
  logic [7:0]  tx_byte;
  logic [15:0] len_field, didx;
  logic [63:0] bit_src;
  always_comb begin
    len_field = 16'(data_bytes + 16'd3);
    if (fc_reg == mtsf_pkg::FC_WR_RELAY || fc_reg == mtsf_pkg::FC_WR_REGS || err_reg)
      len_field = err_reg ? 16'd3 : 16'd6;
    didx    = 16'(tx_cnt_reg) - 16'd9;
    bit_src = (fc_reg == mtsf_pkg::FC_RD_RELAY) ? {56'h0, relay_reg} : {26'h0, din_val_reg};
    case (tx_cnt_reg)
      9'd0:    tx_byte = tid_reg[15:8];
      9'd1:    tx_byte = tid_reg[7:0];
      9'd2:    tx_byte = 8'h00;
      9'd3:    tx_byte = 8'h00;
      9'd4:    tx_byte = len_field[15:8];
      9'd5:    tx_byte = len_field[7:0];
      9'd6:    tx_byte = uid_reg;
      9'd7:    tx_byte = err_reg ? (fc_reg | 8'h80) : fc_reg;
      default: tx_byte = 8'h00;
    endcase
    if (tx_cnt_reg >= 9'd8) begin
      if (err_reg) begin
        tx_byte = 8'h01;
      end else if (fc_reg == mtsf_pkg::FC_WR_RELAY || fc_reg == mtsf_pkg::FC_WR_REGS) begin
        case (tx_cnt_reg)
          9'd8:    tx_byte = start_reg[15:8];
          9'd9:    tx_byte = start_reg[7:0];
          9'd10:   tx_byte = qty_reg[15:8];                // echo of value or count
          default: tx_byte = qty_reg[7:0];
        endcase
      end else if (tx_cnt_reg == 9'd8) begin
        tx_byte = data_bytes[7:0];
      end else if (fc_reg == mtsf_pkg::FC_RD_REGS) begin
        tx_byte = didx[0] ? mem.rdata[7:0] : mem.rdata[15:8];
      end else begin
        tx_byte = pack_bits(bit_src, start_reg, qty_reg, didx,
                            (fc_reg == mtsf_pkg::FC_RD_RELAY) ? 16'(mtsf_pkg::RELAY_COUNT)
                                                              : 16'(mtsf_pkg::DIN_COUNT));
      end
    end
  end

  // request check after the fixed part of the frame
  logic req_ok, fc_known, range_ok;
  always_comb begin
    fc_known = (fc_reg == mtsf_pkg::FC_RD_RELAY) || (fc_reg == mtsf_pkg::FC_RD_DIN) ||
               (fc_reg == mtsf_pkg::FC_RD_REGS) || (fc_reg == mtsf_pkg::FC_WR_RELAY) ||
               (fc_reg == mtsf_pkg::FC_WR_REGS);
    case (fc_reg)
      mtsf_pkg::FC_RD_RELAY: range_ok = qty_reg != 0 &&
                                        (start_reg + qty_reg) <= 16'(mtsf_pkg::RELAY_COUNT);
      mtsf_pkg::FC_RD_DIN:   range_ok = qty_reg != 0 &&
                                        (start_reg + qty_reg) <= 16'(mtsf_pkg::DIN_COUNT);
      mtsf_pkg::FC_RD_REGS:  range_ok = qty_reg != 0 && qty_reg <= 16'd125 &&
                                        (start_reg + qty_reg) <= 16'(REG_DEPTH);
      mtsf_pkg::FC_WR_RELAY: range_ok = start_reg < 16'd8;
      mtsf_pkg::FC_WR_REGS:  range_ok = (start_reg + qty_reg) <= 16'(REG_DEPTH);
      default:               range_ok = 1'b0;
    endcase
    req_ok = fc_known && range_ok && (pid_reg == 16'h0000);
  end

  // receive, execute and transmit sequencing
  always_comb begin
    state_next    = state_reg;
    rx_cnt_next   = rx_cnt_reg;
    tid_next      = tid_reg;
    pid_next      = pid_reg;
    uid_next      = uid_reg;
    fc_next       = fc_reg;
    start_next    = start_reg;
    qty_next      = qty_reg;
    hi_next       = hi_reg;
    relay_next    = relay_reg;
    tx_cnt_next   = tx_cnt_reg;
    tx_len_next   = tx_len_reg;
    tx_data_next  = tx_data_reg;
    tx_valid_next = tx_valid_reg;
    tx_last_next  = tx_last_reg;
    we_next       = 1'b0;
    waddr_next    = waddr_reg;
    wdata_next    = wdata_reg;
    raddr_next    = raddr_reg;
    err_next      = err_reg;
    case (state_reg)
      mtsf_pkg::MTSF_IDLE, mtsf_pkg::MTSF_RX: begin
        if (rx_valid_i) begin
          state_next  = mtsf_pkg::MTSF_RX;
          rx_cnt_next = 9'(rx_cnt_reg + 9'd1);
          case (rx_cnt_reg)
            9'd0:  tid_next[15:8]   = rx_data_i;
            9'd1:  tid_next[7:0]    = rx_data_i;
            9'd2:  pid_next[15:8]   = rx_data_i;
            9'd3:  pid_next[7:0]    = rx_data_i;
            9'd6:  uid_next         = rx_data_i;
            9'd7:  fc_next          = rx_data_i;
            9'd8:  start_next[15:8] = rx_data_i;
            9'd9:  start_next[7:0]  = rx_data_i;
            9'd10: qty_next[15:8]   = rx_data_i;
            9'd11: qty_next[7:0]    = rx_data_i;
            default: begin
              // multi-write payload pairs after byte count at 12
              // writes land as bytes arrive, so the station match must gate them here
              if (rx_cnt_reg >= 9'd13 && fc_reg == mtsf_pkg::FC_WR_REGS &&
                  pid_reg == 16'h0000 && uid_reg == unit_addr_i &&
                  unit_addr_i <= mtsf_pkg::UNIT_MAX) begin
                if (rx_cnt_reg[0]) begin
                  hi_next = rx_data_i;
                end else if (16'((rx_cnt_reg - 9'd14) >> 1) < qty_reg &&
                             (start_reg + qty_reg) <= 16'(REG_DEPTH)) begin
                  we_next    = 1'b1;
                  waddr_next = 8'(start_reg + 16'((rx_cnt_reg - 9'd14) >> 1));
                  wdata_next = {hi_reg, rx_data_i};
                end
              end
            end
          endcase
          if (rx_last_i) begin
            rx_cnt_next = 9'd0;
            // frames for other stations are dropped silently
            state_next  = (uid_next == unit_addr_i && unit_addr_i <= mtsf_pkg::UNIT_MAX)
                          ? mtsf_pkg::MTSF_EXEC : mtsf_pkg::MTSF_IDLE;
          end
        end
      end
      mtsf_pkg::MTSF_EXEC: begin
        err_next = !req_ok;
        if (req_ok && fc_reg == mtsf_pkg::FC_WR_RELAY) begin
          if (qty_reg == mtsf_pkg::RELAY_ON_VAL) relay_next[start_reg[2:0]] = 1'b1;
          else if (qty_reg == mtsf_pkg::RELAY_OFF_VAL) relay_next[start_reg[2:0]] = 1'b0;
        end
        raddr_next  = start_reg[7:0];
        tx_cnt_next = 9'd0;
        state_next  = mtsf_pkg::MTSF_WRITE;
      end
      mtsf_pkg::MTSF_WRITE: begin
        // one spare cycle lets the first register read settle
        tx_len_next   = 9'(len_field + 16'd6);
        tx_data_next  = tx_byte;
        tx_valid_next = 1'b1;
        tx_last_next  = 1'b0;
        state_next    = mtsf_pkg::MTSF_TX;
      end
      mtsf_pkg::MTSF_TX: begin
        if (tx_ready_i) begin
          if (tx_cnt_reg == 9'(tx_len_reg - 9'd1)) begin
            tx_valid_next = 1'b0;
            tx_last_next  = 1'b0;
            state_next    = mtsf_pkg::MTSF_IDLE;
          end else begin
            tx_cnt_next = 9'(tx_cnt_reg + 9'd1);
            if (tx_cnt_reg >= 9'd9 && tx_cnt_reg[0]) raddr_next = 8'(raddr_reg + 8'd1);
            state_next  = mtsf_pkg::MTSF_WRITE;
            tx_valid_next = 1'b0;
          end
        end
      end
      default: state_next = mtsf_pkg::MTSF_IDLE;
    endcase
    if (state_reg == mtsf_pkg::MTSF_WRITE) begin
      tx_last_next = (tx_cnt_reg == 9'(tx_len_next - 9'd1));
    end
    busy_next = (state_next != mtsf_pkg::MTSF_IDLE);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg    <= mtsf_pkg::MTSF_IDLE;
      rx_cnt_reg   <= '0;
      tid_reg      <= '0;
      pid_reg      <= '0;
      uid_reg      <= '0;
      fc_reg       <= '0;
      start_reg    <= '0;
      qty_reg      <= '0;
      hi_reg       <= '0;
      relay_reg    <= mtsf_pkg::RELAY_RESET;
      tx_cnt_reg   <= '0;
      tx_len_reg   <= '0;
      tx_data_reg  <= '0;
      tx_valid_reg <= 1'b0;
      tx_last_reg  <= 1'b0;
      we_reg       <= 1'b0;
      waddr_reg    <= '0;
      wdata_reg    <= '0;
      raddr_reg    <= '0;
      err_reg      <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      rx_cnt_reg   <= rx_cnt_next;
      tid_reg      <= tid_next;
      pid_reg      <= pid_next;
      uid_reg      <= uid_next;
      fc_reg       <= fc_next;
      start_reg    <= start_next;
      qty_reg      <= qty_next;
      hi_reg       <= hi_next;
      relay_reg    <= relay_next;
      tx_cnt_reg   <= tx_cnt_next;
      tx_len_reg   <= tx_len_next;
      tx_data_reg  <= tx_data_next;
      tx_valid_reg <= tx_valid_next;
      tx_last_reg  <= tx_last_next;
      we_reg       <= we_next;
      waddr_reg    <= waddr_next;
      wdata_reg    <= wdata_next;
      raddr_reg    <= raddr_next;
      err_reg      <= err_next;
      busy_reg     <= busy_next;
    end
  end

  // memory port and registered outputs
  assign mem.we    = we_reg;
  assign mem.waddr = waddr_reg;
  assign mem.wdata = wdata_reg;
  assign mem.raddr = raddr_reg;
  assign tx_data_o  = tx_data_reg;
  assign tx_valid_o = tx_valid_reg;
  assign tx_last_o  = tx_last_reg;
  assign relay_o    = relay_reg;
  assign busy_o     = busy_reg;
endmodule : mtsf_server

// file: testbench/mtsf_server_properties.sv
// mtsf_server_properties: port-level checks of the server frame engine
`timescale 1ns/10ps
module mtsf_server_properties #(
  parameter int REG_DEPTH = 256
) (
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic [7:0]  rx_data_i,
  input wire logic        rx_valid_i,
  input wire logic        rx_last_i,
  input wire logic [7:0]  unit_addr_i,
  input wire logic [37:0] din_i,
  input wire logic        tx_ready_i,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_last_o,
  input wire logic [7:0]  relay_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // ------------------------------------------------------------
  // reply stream
  // ------------------------------------------------------------
  a_reset_clears: assert property (disable iff (1'h0)
    srst_i |=> !tx_valid_o && relay_o == 8'h00) else $error("reset left state");
  a_byte_holds: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("reply byte moved while stalled");
  a_byte_gap: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
    else $error("no gap after taken byte");
  a_reply_busy: assert property (tx_valid_o |-> busy_o)
    else $error("reply while idle");
  a_done_idle: assert property (tx_valid_o && tx_ready_i && tx_last_o |-> ##[1:4] !busy_o)
    else $error("engine stuck after reply");
  a_last_once: assert property (tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o [*2])
    else $error("bytes after final byte");
  // ------------------------------------------------------------
  // relay state
  // ------------------------------------------------------------
  // relays move only while a frame is being handled, one at a time
  a_relay_hold: assert property (!busy_o ##1 !busy_o |-> $stable(relay_o))
    else $error("relay moved while idle");
  a_one_relay: assert property ($changed(relay_o) |-> $onehot(relay_o ^ $past(relay_o)))
    else $error("more than one relay moved");
  a_relay_first: assert property (tx_valid_o |=> $stable(relay_o))
    else $error("relay moved during reply");
endmodule : mtsf_server_properties

bind mtsf_server mtsf_server_properties #(.REG_DEPTH(REG_DEPTH)) mtsf_server_properties_i (
  .clock_i(clock_i), .srst_i(srst_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
  .rx_last_i(rx_last_i), .unit_addr_i(unit_addr_i), .din_i(din_i), .tx_ready_i(tx_ready_i),
  .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
  .relay_o(relay_o), .busy_o(busy_o));

// file: testbench/mtsf_client_sink.sv
// mtsf_client_sink: client model taking reply bytes, fast or stalling
`timescale 1ns/10ps
module mtsf_client_sink (
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_last_i,
  output logic            tx_ready_o
);
  logic [7:0] got[$];
  int         frames;
  logic [1:0] phase;
  // ------------------------------------------------------------
  // capture
  // ------------------------------------------------------------
  // one byte per valid-ready edge; the final flag closes one reply
  always @(posedge clock_i) begin
    if (srst_i) begin
      phase <= 2'h0;
      frames <= 0;
    end else begin
      phase <= phase + 2'h1;
      if (tx_valid_i && tx_ready_o) begin
        got.push_back(tx_data_i); // every reply byte kept for comparison with the expected frame
        if (tx_last_i) frames <= frames + 1;
      end
    end
  end
  // slow mode stalls three edges in four, so the reply must hold its byte
  always @(posedge clock_i) begin
    #1 tx_ready_o <= !srst_i && (!slow_i || (phase == 2'h3));
  end
endmodule : mtsf_client_sink

// file: testbench/mtsf_server_tb_top.sv
// mtsf_server_tb_top: self-checking bench for the server frame engine
`timescale 1ns/10ps
module mtsf_server_tb_top;
  typedef logic [7:0] mtsf_bytes_t[$];
  logic        clock_i = 1'h0;
  logic        srst_i  = 1'h1;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_valid = 1'h0;
  logic        rx_last = 1'h0;
  logic [7:0]  unit    = 8'h01;
  logic [37:0] din     = 38'h00_0000_0000;
  logic        slow    = 1'h0;
  logic        tx_ready, tx_valid, tx_last, busy;
  logic [7:0]  tx_data, relay;
  int          bad_count = 0;
  int          comparisons = 0;
  always #4 clock_i = ~clock_i;
  mtsf_server #(.REG_DEPTH(256)) mtsf_server_i (.clock_i(clock_i), .srst_i(srst_i),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_last_i(rx_last), .unit_addr_i(unit),
    .din_i(din), .tx_ready_i(tx_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
    .tx_last_o(tx_last), .relay_o(relay), .busy_o(busy));
  mtsf_client_sink mtsf_client_sink_i (.clock_i(clock_i), .srst_i(srst_i), .slow_i(slow),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_last_i(tx_last), .tx_ready_o(tx_ready));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("counts: %0d compared, %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  // header, zero protocol id, length of unit, code and data
  function automatic mtsf_bytes_t frame(input logic [15:0] tid, input logic [7:0] fc,
                                        input mtsf_bytes_t d);
    mtsf_bytes_t f;
    f = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'(d.size() + 2), unit, fc};
    return {f, d};
  endfunction : frame
  // mode 0 compares the reply, 1 only waits for it, 2 expects none
  task automatic run(input mtsf_bytes_t req, input mtsf_bytes_t e, input int mode);
    int n;
    int f0;
    n = 0;
    while (busy !== 1'h0 && n < 300) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      $display("unexpected at %0t: engine stuck busy", $time);
      close_out();
    end
    mtsf_client_sink_i.got.delete();
    f0 = mtsf_client_sink_i.frames;
    foreach (req[i]) begin
      @(posedge clock_i);
      #1;
      rx_data = req[i];
      rx_valid = 1'h1;
      rx_last = (i == req.size() - 1);
    end
    @(posedge clock_i);
    #1;
    rx_valid = 1'h0;
    rx_last = 1'h0;
    n = 0;
    while (mtsf_client_sink_i.frames == f0 && n < 300) begin
      @(posedge clock_i);
      n++;
    end
    if (mode == 2) begin
      check(8'(mtsf_client_sink_i.got.size()), 8'h00, "dropped frame answered");
    end else if (n >= 300) begin
      bad_count++;
      $display("unexpected at %0t: no reply", $time);
      close_out();
    end else if (mode == 0) begin
      check(8'(mtsf_client_sink_i.got.size()), 8'(e.size()), "reply size");
      foreach (e[i]) check(mtsf_client_sink_i.got[i], e[i], "reply byte");
    end
  endtask : run
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_relays();
    mtsf_bytes_t q;
    q = frame(16'h0101, 8'h05, '{8'h00, 8'h03, 8'hFF, 8'h00});
    run(q, q, 0);
    q = frame(16'h0102, 8'h05, '{8'h00, 8'h00, 8'hFF, 8'h00});
    run(q, q, 0);
    check(relay, 8'h09, "relays 0 and 3");
    q = frame(16'h0103, 8'h05, '{8'h00, 8'h03, 8'h12, 8'h34});
    run(q, q, 0);
    check(relay, 8'h09, "odd value");
    slow = 1'h1;
    run(frame(16'h0104, 8'h01, '{8'h00, 8'h00, 8'h00, 8'h08}),
      frame(16'h0104, 8'h01, '{8'h01, 8'h09}), 0);
    run(frame(16'h0105, 8'h01, '{8'h00, 8'h03, 8'h00, 8'h02}),
      frame(16'h0105, 8'h01, '{8'h01, 8'h01}), 0);
    slow = 1'h0;
    q = frame(16'h0106, 8'h05, '{8'h00, 8'h03, 8'h00, 8'h00});
    run(q, q, 0);
    check(relay, 8'h01, "relay 3 off");
    $display("relay test done");
  endtask : t_relays
  task automatic t_din();
    #1;
    din = {2'h2, 36'h0_0000_000B};
    unit = 8'hF7; // top station address
    repeat (4) @(posedge clock_i);
    run(frame(16'h0201, 8'h02, '{8'h00, 8'h00, 8'h00, 8'h04}),
      frame(16'h0201, 8'h02, '{8'h01, 8'h0B}), 0);
    run(frame(16'h0202, 8'h02, '{8'h00, 8'h24, 8'h00, 8'h02}),
      frame(16'h0202, 8'h02, '{8'h01, 8'h02}), 0);
    #1;
    unit = 8'h01;
    $display("input test done");
  endtask : t_din
  task automatic t_regs();
    // start, count, byte count, then data, high byte first
    run(frame(16'h0301, 8'h10, '{8'h00, 8'h10, 8'h00, 8'h02, 8'h04, 8'h01, 8'hF4, 8'h00,
      8'h05}), frame(16'h0301, 8'h10, '{8'h00, 8'h10, 8'h00, 8'h02}), 0);
    run(frame(16'h0302, 8'h03, '{8'h00, 8'h10, 8'h00, 8'h02}),
      frame(16'h0302, 8'h03, '{8'h04, 8'h01, 8'hF4, 8'h00, 8'h05}), 0);
    $display("register test done");
  endtask : t_regs
  task automatic t_bad();
    mtsf_bytes_t q;
    run(frame(16'h0401, 8'h07, '{8'h00, 8'h00}), frame(16'h0401, 8'h87, '{8'h01}), 0);
    q = frame(16'h0402, 8'h05, '{8'h00, 8'h05, 8'hFF, 8'h00});
    q[3] = 8'h01;
    run(q, q, 1);
    check(relay, 8'h01, "protocol id");
    q[3] = 8'h00;
    q[6] = 8'h02;
    run(q, q, 2);
    check(relay, 8'h01, "other unit");
    q = frame(16'h0403, 8'h10, '{8'h00, 8'h10, 8'h00, 8'h01, 8'h02, 8'hAB, 8'hCD});
    q[6] = 8'h02;
    run(q, q, 2);
    run(frame(16'h0404, 8'h03, '{8'h00, 8'h10, 8'h00, 8'h01}),
      frame(16'h0404, 8'h03, '{8'h02, 8'h01, 8'hF4}), 0);
    $display("refusal test done");
  endtask : t_bad
  initial begin
    repeat (6) @(posedge clock_i);
    #1;
    srst_i = 1'h0; // link is open before the first request
    check(relay, mtsf_pkg::RELAY_RESET, "relay reset");
    t_relays();
    t_din();
    t_regs();
    t_bad();
    close_out();
  end
endmodule : mtsf_server_tb_top
